// *** hpa_defines.vh ***
// Purpose: constants for the max address security command block
// Assumes: included by hpa_core.v only
// Notes:   control register offsets are byte addresses on Avalon-MM
`ifndef HPA_DEFINES_VH
`define HPA_DEFINES_VH
// Command opcodes
`define HPA_OP_READ_NATIVE  8'hF8
`define HPA_OP_SET_MAX      8'hF9
// Feature field sub-function codes
`define HPA_FEAT_SET_MAX    8'h00
`define HPA_FEAT_SET_PWD    8'h01
`define HPA_FEAT_LOCK       8'h02
`define HPA_FEAT_UNLOCK     8'h03
`define HPA_FEAT_FREEZE     8'h04
// Register byte offsets
`define HPA_REG_CMD         4'h0
`define HPA_REG_LBA         4'h4
`define HPA_REG_STATUS      4'h8
`define HPA_REG_RESULT      4'hC
// Command register field positions
`define HPA_CMD_OP_LSB      0
`define HPA_CMD_FEAT_LSB    8
`define HPA_CMD_VOL_BIT     16
`define HPA_CMD_GO_BIT      31
// Password buffer window: byte offset 0x40, words 0..15
`define HPA_PWD_BASE_BIT    6
// Limits and the counter value loaded at lock
`define HPA_LBA28_MAX       28'hFFFFFFF
`define HPA_UNLOCK_TRIES    3'h5
// Security mode codes, one-hot
`define HPA_MODE_INACTIVE   4'h1
`define HPA_MODE_UNLOCKED   4'h2
`define HPA_MODE_LOCKED     4'h4
`define HPA_MODE_FROZEN     4'h8
`endif

// *** hpa_core.v ***
// Purpose: max address limit and password security state for one drive
// Assumes: firmware hands decoded commands in over Avalon-MM
// Notes:   power_rst is power-on; link resets never reach this block
//
// Behaviour
// - Opcode F8h reads native max, F9h sets max address.
// - Set password, lock, unlock, freeze are F9h sub-functions by feature.
// - 28-bit native max read saturates at 268,435,455.
// - Native max read returns the native max whatever the current limit.
// - Lowered limit holds until another Set Max Address raises it.
// - Volatile limit is discarded at power-on or reset.
// - Set password stores password for power cycle, enters unlocked.
// - Password is words 1-16 of the transferred sector, 32 bytes.
// - Lock enters locked; only unlock and freeze allowed afterwards.
// - Matching unlock moves locked mode to unlocked mode.
// - Mismatching unlock aborts and decrements the attempt counter.
// - Lock loads counter with five; only locked mismatches decrement.
// - In locked mode, counter at zero aborts every unlock until power cycle.
// - Freeze enters frozen mode and rejects all Set Max commands.
// - Password, mode, counter clear at power cycle, survive link reset.
// - F9h right after F8h is plain Set Max Address.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "hpa_defines.vh"

module hpa_core #(
	parameter LBA_W = 48
) (
	// Clock and resets
	input  wire             ref_clk,
	input  wire             sys_rst,
	input  wire             power_rst,
	// Native capacity and stored limit from the media layer
	input  wire [LBA_W-1:0] native_max,
	input  wire [LBA_W-1:0] nv_max,
	// Avalon-MM slave
	input  wire [6:0]       avs_address,
	input  wire             avs_read,
	input  wire             avs_write,
	input  wire [31:0]      avs_writedata,
	output reg  [31:0]      avs_readdata,
	output reg              avs_waitrequest,
	// Results to the drive
	output reg  [LBA_W-1:0] max_lba,
	output reg              nv_store,
	output reg  [LBA_W-1:0] nv_value
);

	// Live state
	reg [3:0]       mode;
	reg [2:0]       tries;
	reg [255:0]     pwd;
	reg [255:0]     buf_pwd;
	reg             pwd_set;
	reg             last_rnm;
	reg [LBA_W-1:0] lba_arg;
	reg [LBA_W-1:0] result;
	reg             aborted;
	reg             done;
	reg [LBA_W-1:0] next_max;
	reg [3:0]       next_mode;
	reg [2:0]       next_tries;
	reg             next_abort;
	reg             next_store_pwd;

	wire       acc   = (avs_read | avs_write) & avs_waitrequest;
	wire       go    = acc & avs_write & (avs_address[6:2] == 5'h00)
		& avs_writedata[`HPA_CMD_GO_BIT];
	wire [7:0] op    = avs_writedata[`HPA_CMD_OP_LSB +: 8];
	wire [7:0] feat  = avs_writedata[`HPA_CMD_FEAT_LSB +: 8];
	wire       vol   = avs_writedata[`HPA_CMD_VOL_BIT];
	wire       match = (buf_pwd == pwd);
	// Native max above the 28-bit ceiling, picks the saturated read
	wire       big   = (native_max > {{(LBA_W-28){1'b0}}, `HPA_LBA28_MAX});

	// Command decode and security transitions
	always @* begin
		next_max       = max_lba;
		next_mode      = mode;
		next_tries     = tries;
		next_abort     = 1'b0;
		next_store_pwd = 1'b0;
		if (op == `HPA_OP_SET_MAX) begin
			if (last_rnm || feat == `HPA_FEAT_SET_MAX) begin
				// Locked or frozen rejects address change
				if (mode == `HPA_MODE_LOCKED || mode == `HPA_MODE_FROZEN)
					next_abort = 1'b1;
				else
					next_max = lba_arg;
			end else begin
				case (feat)
				`HPA_FEAT_SET_PWD: begin
					if (mode == `HPA_MODE_LOCKED || mode == `HPA_MODE_FROZEN)
						next_abort = 1'b1;
					else begin
						next_store_pwd = 1'b1;
						next_mode      = `HPA_MODE_UNLOCKED;
					end
				end
				`HPA_FEAT_LOCK: begin
					if (mode != `HPA_MODE_UNLOCKED)
						next_abort = 1'b1;
					else begin
						next_mode  = `HPA_MODE_LOCKED;
						next_tries = `HPA_UNLOCK_TRIES;
					end
				end
				`HPA_FEAT_UNLOCK: begin
					if (mode == `HPA_MODE_FROZEN)
						next_abort = 1'b1;
					else if (mode == `HPA_MODE_LOCKED && tries == 3'h0)
						next_abort = 1'b1;
					else if (mode == `HPA_MODE_LOCKED && match)
						next_mode = `HPA_MODE_UNLOCKED;
					else if (mode == `HPA_MODE_LOCKED) begin
						next_abort = 1'b1;
						next_tries = tries - 3'h1;
					end else if (!match)
						next_abort = 1'b1;
				end
				`HPA_FEAT_FREEZE: begin
					if (mode == `HPA_MODE_FROZEN || mode == `HPA_MODE_INACTIVE)
						next_abort = 1'b1;
					else
						next_mode = `HPA_MODE_FROZEN;
				end
				default: next_abort = 1'b1;
				endcase
			end
		end else if (op != `HPA_OP_READ_NATIVE)
			next_abort = 1'b1;
	end

	// Security state: power-on only
	always @(posedge ref_clk) begin
		if (power_rst) begin
			mode    <= `HPA_MODE_INACTIVE;
			tries   <= 3'h0;
			pwd     <= 256'h0;
			pwd_set <= 1'b0;
		end else if (go) begin
			mode  <= next_mode;
			tries <= next_tries;
			if (next_store_pwd) begin
				pwd     <= buf_pwd;
				pwd_set <= 1'b1;
			end
		end
	end

	// Limit and bus state: any reset
	always @(posedge ref_clk) begin
		if (sys_rst || power_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
			buf_pwd         <= 256'h0;
			lba_arg         <= {LBA_W{1'b0}};
			last_rnm        <= 1'b0;
			result          <= {LBA_W{1'b0}};
			aborted         <= 1'b0;
			done            <= 1'b0;
			nv_store        <= 1'b0;
			nv_value        <= {LBA_W{1'b0}};
			// Volatile limit dropped, fall back to stored one
			max_lba         <= nv_max;
		end else begin
			avs_waitrequest <= ~acc;
			nv_store        <= 1'b0;
			if (acc && avs_write) begin
				// Password words 1-16 land in 0x40..0x7C
				if (avs_address[`HPA_PWD_BASE_BIT])
					buf_pwd[avs_address[5:2]*16 +: 16]
						<= avs_writedata[15:0];
				// High word first, then low word shifts it up
				else if (avs_address[5:0] == {2'b00, `HPA_REG_LBA})
					lba_arg <= {lba_arg[LBA_W-33:0], avs_writedata};
			end
			if (go) begin
				done     <= 1'b1;
				aborted  <= next_abort;
				last_rnm <= (op == `HPA_OP_READ_NATIVE);
				if (op == `HPA_OP_READ_NATIVE)
					// Native max, saturated at 28 bits, whatever the limit
					result <= big ? {{(LBA_W-28){1'b0}}, `HPA_LBA28_MAX}
						: native_max;
				if (!next_abort) begin
					max_lba <= next_max;
					if (next_max != max_lba && !vol) begin
						nv_store <= 1'b1;
						nv_value <= next_max;
					end
				end
			end
			if (acc && avs_read) begin
				case (avs_address[5:0])
				{2'b00, `HPA_REG_CMD}:    avs_readdata <= {31'h0, done};
				{2'b00, `HPA_REG_LBA}:    avs_readdata <= result[31:0];
				{2'b00, `HPA_REG_STATUS}: avs_readdata <= {21'h0, pwd_set,
					tries, aborted, mode, 2'b00};
				{2'b00, `HPA_REG_RESULT}: avs_readdata <=
					{16'h0, result[LBA_W-1:32]};
				default:                  avs_readdata <= 32'h0;
				endcase
			end
		end
	end

endmodule // hpa_core

// *** hpa_core_sva.sv ***
// Purpose: bus and reset checks for hpa_core
// Assumes: nv_max steady through reset
// Notes:   bound into every hpa_core
`timescale 1ns/100ps
module hpa_core_sva #(parameter LBA_W = 48) (
	// Clock and resets
	input wire             ref_clk,
	input wire             sys_rst,
	input wire             power_rst,
	// Stored limit, bus and results
	input wire [LBA_W-1:0] nv_max,
	input wire             avs_read,
	input wire             avs_write,
	input wire [31:0]      avs_readdata,
	input wire             avs_waitrequest,
	input wire [LBA_W-1:0] max_lba,
	input wire             nv_store
);
	wire rst = sys_rst | power_rst;
	wire req = avs_read | avs_write;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Reset values, seen while reset holds
	rst_wait_a: assert property (disable iff (1'b0) rst |=> avs_waitrequest)
		else $error("wait low in reset");
	// Volatile limit back to stored
	rst_limit_a: assert property (disable iff (1'b0)
		rst |=> max_lba == nv_max) else $error("limit kept");
	rst_store_a: assert property (disable iff (1'b0) rst |=> !nv_store)
		else $error("store in reset");
	// One wait cycle, one answer cycle, never unasked
	ack_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer late");
	ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	ack_cause_a: assert property (!avs_waitrequest |-> $past(req))
		else $error("answer unasked");
	// Read data move only with a read answer
	rd_hold_a: assert property (!$stable(avs_readdata) |->
		!avs_waitrequest && $past(avs_read)) else $error("data moved");
	store_one_a: assert property (nv_store |=> !nv_store)
		else $error("store too long");
	// Main scenarios
	cover property (avs_write && !avs_waitrequest);
	cover property (avs_read && !avs_waitrequest);
	cover property (nv_store);
endmodule // hpa_core_sva
bind hpa_core hpa_core_sva #(.LBA_W(LBA_W)) chk (.ref_clk, .sys_rst,
	.power_rst, .nv_max, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .max_lba, .nv_store);

// *** hpa_host.sv ***
// Purpose: host issuing commands over Avalon-MM
// Assumes: xfer is called just after a rising edge
// Notes:   one idle cycle between transfers
`timescale 1ns/100ps
module hpa_host (
	// Clock
	input wire         ref_clk,
	// Avalon-MM master
	input wire         avs_waitrequest,
	input wire  [31:0] avs_readdata,
	output reg  [6:0]  avs_address = 7'h00,
	output reg         avs_read = 1'b0,
	output reg         avs_write = 1'b0,
	output reg  [31:0] avs_writedata = 32'h0
);
	// Hold request until waitrequest is seen low
	task xfer(input w, input [6:0] a, input [31:0] d, output [31:0] q);
		begin
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		q = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_writedata <= ~d; // Stale data not left on the bus
		end
	endtask
endmodule // hpa_host

// *** hpa_core_tb.sv ***
// Purpose: self-checking bench for hpa_core
// Assumes: hpa_host drives the bus
// Notes:   an integer model predicts every result
`timescale 1ns/100ps
module hpa_core_tb;
	reg          ref_clk = 1'b0, sys_rst = 1'b1, power_rst = 1'b1;
	reg  [47:0]  native_max = 48'h0, nvl = 48'h0, lim, mnv, e;
	wire [6:0]   avs_address;
	wire         avs_read, avs_write, avs_waitrequest, nv_store;
	wire [31:0]  avs_writedata, avs_readdata;
	wire [47:0]  max_lba, nv_value;
	reg  [31:0]  q;
	reg  [15:0]  hi;
	reg  [255:0] pn, ps;
	integer      n_mismatch = 0, num_checks = 0, cyc = 0, seed = 75600;
	integer      i, k, mode, tries, pset, ab, f8;
	hpa_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.power_rst(power_rst), .native_max(native_max), .nv_max(nvl),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.max_lba(max_lba), .nv_store(nv_store), .nv_value(nv_value));
	hpa_host host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata));
	// Clock, timeout, and media keeping the stored limit
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (nv_store) nvl <= nv_value;
		if (cyc == 20000) begin n_mismatch = n_mismatch + 1; end_sim; end
	end
	task end_sim;
		begin
		if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
		end
	endtask
	task chk(input [47:0] g, input [47:0] x);
		begin
		num_checks = num_checks + 1;
		if (g !== x) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: got %h exp %h", $time, g, x);
		end
		end
	endtask
	// Reset held ten cycles; power reset also clears security state
	task rst(input p);
		begin
		sys_rst <= 1'b1;
		power_rst <= p;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		power_rst <= 1'b0;
		lim = mnv;
		f8 = 0;
		if (p) begin mode = 1; tries = 0; pset = 0; end
		end
	endtask
	// One command: bus traffic, model step, then compare all results
	task cmd(input [7:0] op, input [7:0] ft, input vol, input [47:0] a);
		begin
		ab = 0;
		if (ft == 8'h01 || ft == 8'h03) for (k = 0; k < 16; k = k + 1)
			host.xfer(1'b1, {1'b1, k[3:0], 2'b00}, {16'h0, pn[16*k +: 16]}, q);
		host.xfer(1'b1, 7'h04, {16'h0, a[47:32]}, q);
		host.xfer(1'b1, 7'h04, a[31:0], q);
		host.xfer(1'b1, 7'h00, {1'b1, 14'h0, vol, ft, op}, q);
		q = 32'h0;
		for (k = 0; k < 9 && !q[0]; k = k + 1) host.xfer(1'b0, 7'h00, 32'h0, q);
		if (op == 8'hF8) e = native_max > 48'hFFFFFFF ? 48'hFFFFFFF : native_max;
		else if (op != 8'hF9) ab = 1;
		else case (f8 ? 8'h00 : ft)
		8'h00: begin
			ab = mode > 2;
			if (!ab) lim = a;
			if (!ab && !vol) mnv = a;
		end
		8'h01: if (mode > 2) ab = 1; else begin mode = 2; pset = 1; ps = pn; end
		8'h02: if (mode == 2) begin mode = 4; tries = 5; end else ab = 1;
		8'h03: begin
			ab = mode == 8 || mode == 4 && tries == 0 || pn != ps;
			if (!ab) mode = 2;
			else if (mode == 4 && tries > 0) tries = tries - 1;
		end
		default: if (mode == 2 || mode == 4) mode = 8; else ab = 1;
		endcase
		f8 = op == 8'hF8;
		host.xfer(1'b0, 7'h08, 32'h0, q);
		chk({39'h0, q[10:2]}, {39'h0, pset[0], tries[2:0], ab[0], mode[3:0]});
		chk(max_lba, lim);
		if (f8) begin
			host.xfer(1'b0, 7'h0C, 32'h0, q);
			hi = q[15:0];
			host.xfer(1'b0, 7'h04, 32'h0, q);
			chk({hi, q}, e);
		end
		end
	endtask
	initial begin
		mnv = 48'h0;
		pn = 256'h0;
		ps = 256'h0;
		rst(1'b1);
		// Native read at, past and around the 28-bit ceiling
		for (i = 0; i < 4; i = i + 1) begin
			q = $random(seed);
			native_max <= i < 2 ? 48'hFFFFFFF + i : {q[15:0] & {16{i[0]}}, q};
			cmd(8'hF8, 8'h00, 1'b0, 48'h0);
		end
		q = $random(seed);
		cmd(8'hF9, 8'h02, 1'b0, {q[15:0], ~q});
		cmd(8'hF9, 8'h00, 1'b1, 48'h0FFFFF);
		rst(1'b0);
		cmd(8'hF8, 8'h00, 1'b0, 48'h0);
		cmd(8'hEC, 8'h01, 1'b0, 48'h0);
		for (k = 0; k < 8; k = k + 1) pn[32*k +: 32] = $random(seed);
		cmd(8'hF9, 8'h01, 1'b0, 48'h0);
		cmd(8'hF9, 8'h02, 1'b0, 48'h0);
		cmd(8'hF9, 8'h00, 1'b0, 48'h1);
		rst(1'b0);
		pn[0] = ~pn[0];
		cmd(8'hF9, 8'h03, 1'b0, 48'h0);
		pn[0] = ~pn[0];
		cmd(8'hF9, 8'h03, 1'b0, 48'h0);
		cmd(8'hF9, 8'h02, 1'b0, 48'h0);
		// Five misses empty the counter; a right password then fails
		pn[0] = ~pn[0];
		for (i = 0; i < 5; i = i + 1) cmd(8'hF9, 8'h03, 1'b0, 48'h0);
		pn[0] = ~pn[0];
		cmd(8'hF9, 8'h03, 1'b0, 48'h0);
		cmd(8'hF9, 8'h04, 1'b0, 48'h0);
		cmd(8'hF9, 8'h03, 1'b0, 48'h0);
		rst(1'b1);
		cmd(8'hF9, 8'h02, 1'b0, 48'h0);
		end_sim;
	end
endmodule // hpa_core_tb
